// ===== hdl/dac_ctrl.sv
// Purpose: abstract command launch, busy tracking and error code
// Assumes: debug interface requests and hart signals run on core_clk
// Notes: register reads answer one cycle after the request
`include "dac_cfg.svh"
// Function
// R1: command write starts command if clean, idle
// R2: busy rises on command write, falls after
// R3: status write while busy sets busy error
// R4: command write while busy sets busy error
// R5: argument access while busy sets busy error
// R6: unsupported command gives error two
// R7: memory address outside ranges gives three
// R8: hart unavailable or wrong state gives four
// R9: bad size or unaligned gives seven
// R10: error holds until ones written clear it
// R11: nonzero error blocks new commands
// R12: debugger trusts error only when idle
// R13: debugger may batch commands, check at end
// R14: data count field reads two
// R15: program buffer size field reads zero
// R16: memory command reaches only coupled ranges
// R17: type zero register, two memory access
// R18: size other than two gives seven
// R19: error recorded by the time busy clears
module dac_ctrl #(
    parameter logic [31:0] IMEM_BASE = 32'h1000_0000,
    parameter logic [31:0] IMEM_SIZE = 32'h0001_0000,
    parameter logic [31:0] DMEM_BASE = 32'h2000_0000,
    parameter logic [31:0] DMEM_SIZE = 32'h0001_0000,
    parameter logic [31:0] INTR_BASE = 32'h3000_0000,
    parameter logic [31:0] INTR_SIZE = 32'h0001_0000
) (
    // clock and resets
    input wire logic core_clk,
    input wire logic rst,
    input wire logic dm_active,
    // debug module interface request
    input wire logic dmi_req_valid,
    input wire logic dmi_req_write,
    input wire logic [`DAC_ADDR_W-1:0] dmi_req_addr,
    input wire logic [31:0] dmi_req_wdata,
    // debug module interface answer
    output logic dmi_rsp_valid_r,
    output logic [31:0] dmi_rsp_rdata_r,
    // hart state and memory address argument
    input wire logic hart_halted,
    input wire logic hart_unavail,
    input wire logic [31:0] argument_word_one,
    // execution port to the core
    output logic exec_start_r,
    output logic [31:0] exec_cmd_r,
    input wire logic exec_done,
    input wire logic [2:0] exec_err,
    // status
    output logic busy_r,
    output logic [2:0] cmderr_r
);
    if (IMEM_SIZE == 32'h0 || DMEM_SIZE == 32'h0 || INTR_SIZE == 32'h0) begin : g_size_chk
        $error("dac_ctrl: memory range sizes must be nonzero");
    end

    dac_pkg::dac_state_type state_r, state_nxt;
    logic [2:0] fail_code_r;
    logic [2:0] cmderr_nxt;
    logic [2:0] chk_code;

    // request decode
    wire logic is_cs = dmi_req_addr == `DAC_OFS_CTRL_STATUS;
    wire logic is_cmd = dmi_req_addr == `DAC_OFS_CMD_LAUNCH;
    wire logic is_arg = dmi_req_addr == `DAC_OFS_ARG_ZERO || dmi_req_addr == `DAC_OFS_ARG_ONE;
    wire logic cs_wr = dmi_req_valid && dmi_req_write && is_cs;
    wire logic cmd_wr = dmi_req_valid && dmi_req_write && is_cmd;
    wire logic arg_acc = dmi_req_valid && is_arg;
    wire logic err_clean = cmderr_r == dac_pkg::DAC_ERR_NONE;
    wire logic accept = cmd_wr && err_clean && !busy_r; // [R1] [R11]
    wire logic busy_hit = busy_r && err_clean
                        && (cs_wr || cmd_wr || arg_acc); // [R3] [R4] [R5]
    wire logic err_clr = cs_wr
                       && dmi_req_wdata[`DAC_CS_ERR_HI:`DAC_CS_ERR_LO] == `DAC_ERR_CLEAR_ALL;
    wire logic fail_end = state_r == dac_pkg::DAC_ST_FAIL;
    wire logic exec_end = state_r == dac_pkg::DAC_ST_EXEC && exec_done;
    wire logic [31:0] cs_word = {3'h0, `DAC_PBUF_SIZE, 11'h000, busy_r, 1'b0, cmderr_r,
                                 4'h0, `DAC_DATA_COUNT}; // [R14] [R15]

    dac_cmd_check #(
        .IMEM_BASE(IMEM_BASE),
        .IMEM_SIZE(IMEM_SIZE),
        .DMEM_BASE(DMEM_BASE),
        .DMEM_SIZE(DMEM_SIZE),
        .INTR_BASE(INTR_BASE),
        .INTR_SIZE(INTR_SIZE)
    ) u_check (
        .cmd_word(dmi_req_wdata),
        .mem_addr(argument_word_one),
        .hart_halted(hart_halted),
        .hart_unavail(hart_unavail),
        .err_code(chk_code)
    );

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            dac_pkg::DAC_ST_IDLE: begin
                if (accept) begin
                    state_nxt = (chk_code == dac_pkg::DAC_ERR_NONE) ? dac_pkg::DAC_ST_EXEC
                                                                    : dac_pkg::DAC_ST_FAIL;
                end
            end
            dac_pkg::DAC_ST_EXEC: begin
                if (exec_done) begin
                    state_nxt = dac_pkg::DAC_ST_IDLE; // [R2]
                end
            end
            dac_pkg::DAC_ST_FAIL: begin
                state_nxt = dac_pkg::DAC_ST_IDLE; // [R2]
            end
        endcase
    end

    // hardware set wins over software clear
    always_comb begin
        cmderr_nxt = cmderr_r;
        if (err_clr) begin
            cmderr_nxt = dac_pkg::DAC_ERR_NONE; // [R10]
        end
        if (busy_hit) begin
            cmderr_nxt = dac_pkg::DAC_ERR_BUSY; // [R3] [R4] [R5]
        end else if (err_clean && fail_end) begin
            cmderr_nxt = fail_code_r; // [R19]
        end else if (err_clean && exec_end && exec_err != dac_pkg::DAC_ERR_NONE) begin
            cmderr_nxt = exec_err; // [R19]
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_r <= dac_pkg::DAC_ST_IDLE;
            busy_r <= 1'b0;
            cmderr_r <= 3'h0;
            fail_code_r <= 3'h0;
            exec_start_r <= 1'b0;
            exec_cmd_r <= 32'h0;
            dmi_rsp_valid_r <= 1'b0;
            dmi_rsp_rdata_r <= 32'h0;
        end else if (!dm_active) begin
            state_r <= dac_pkg::DAC_ST_IDLE;
            busy_r <= 1'b0;
            cmderr_r <= 3'h0;
            fail_code_r <= 3'h0;
            exec_start_r <= 1'b0;
            exec_cmd_r <= 32'h0;
            dmi_rsp_valid_r <= 1'b0;
            dmi_rsp_rdata_r <= 32'h0;
        end else begin
            state_r <= state_nxt;
            busy_r <= state_nxt != dac_pkg::DAC_ST_IDLE; // [R2]
            cmderr_r <= cmderr_nxt;
            fail_code_r <= accept ? chk_code : fail_code_r;
            exec_start_r <= accept && chk_code == dac_pkg::DAC_ERR_NONE; // [R1]
            exec_cmd_r <= accept ? dmi_req_wdata : exec_cmd_r;
            dmi_rsp_valid_r <= dmi_req_valid;
            dmi_rsp_rdata_r <= (dmi_req_valid && !dmi_req_write && is_cs) ? cs_word : 32'h0;
        end
    end

    // checks
    wire logic chk_rst = rst || !dm_active;
    sequence s_accept_with(logic [2:0] code);
        accept && chk_code == code;
    endsequence
    sequence s_fail_then_idle(logic [2:0] code);
        ##1 busy_r ##1 (!busy_r && cmderr_r == code);
    endsequence

    AST_START_CLEAN: assert property (@(posedge core_clk) disable iff (chk_rst) // [R1]
        exec_start_r |-> $past(cmd_wr) && $past(cmderr_r) == 3'h0 && !$past(busy_r))
        else $error("command started while busy or with error");
    AST_BUSY_RISE: assert property (@(posedge core_clk) disable iff (chk_rst) // [R2]
        accept |=> busy_r)
        else $error("busy did not rise on command write");
    AST_BUSY_FALL: assert property (@(posedge core_clk) disable iff (chk_rst) // [R2]
        (state_r == dac_pkg::DAC_ST_EXEC && exec_done) |=> !busy_r)
        else $error("busy did not fall after completion");
    AST_CS_BUSY_ERR: assert property (@(posedge core_clk) disable iff (chk_rst) // [R3]
        (cs_wr && busy_r && cmderr_r == 3'h0) |=> cmderr_r == 3'h1)
        else $error("status write while busy not flagged");
    AST_CMD_BUSY_ERR: assert property (@(posedge core_clk) disable iff (chk_rst) // [R4]
        (cmd_wr && busy_r && cmderr_r == 3'h0) |=> cmderr_r == 3'h1)
        else $error("command write while busy not flagged");
    AST_ARG_BUSY_ERR: assert property (@(posedge core_clk) disable iff (chk_rst) // [R5]
        (arg_acc && busy_r && cmderr_r == 3'h0) |=> cmderr_r == 3'h1)
        else $error("argument access while busy not flagged");
    AST_UNSUPPORTED: assert property (@(posedge core_clk) disable iff (chk_rst) // [R6]
        s_accept_with(3'h2) |-> s_fail_then_idle(3'h2))
        else $error("unsupported command not reported");
    AST_ADDR_EXC: assert property (@(posedge core_clk) disable iff (chk_rst) // [R7]
        s_accept_with(3'h3) |-> s_fail_then_idle(3'h3))
        else $error("bad address not reported");
    AST_HART_STATE: assert property (@(posedge core_clk) disable iff (chk_rst) // [R8]
        s_accept_with(3'h4) |-> s_fail_then_idle(3'h4))
        else $error("hart state failure not reported");
    AST_SIZE_ERR: assert property (@(posedge core_clk) disable iff (chk_rst) // [R9]
        (accept && dmi_req_wdata[`DAC_CMD_TYPE_HI:`DAC_CMD_TYPE_LO] == 8'h00
         && dmi_req_wdata[`DAC_CMD_SIZE_HI:`DAC_CMD_SIZE_LO] != 3'h2)
        |-> s_fail_then_idle(3'h7))
        else $error("bad size not reported");
    AST_ERR_STICKY: assert property (@(posedge core_clk) disable iff (chk_rst) // [R10]
        (cmderr_r != 3'h0 && !err_clr) |=> $stable(cmderr_r))
        else $error("error code changed without clear");
    AST_ERR_BLOCKS: assert property (@(posedge core_clk) disable iff (chk_rst) // [R11]
        (cmd_wr && cmderr_r != 3'h0 && !busy_r) |=> !busy_r && !exec_start_r)
        else $error("command started with error pending");
    AST_STATUS_FIELDS: assert property (@(posedge core_clk) disable iff (chk_rst) // [R14]
        ($past(dmi_req_valid && !dmi_req_write && is_cs) && dmi_rsp_valid_r)
        |-> dmi_rsp_rdata_r[3:0] == 4'h2 && dmi_rsp_rdata_r[28:24] == 5'h00)
        else $error("status constant fields wrong");
    AST_ERR_BY_IDLE: assert property (@(posedge core_clk) disable iff (chk_rst) // [R19]
        ($fell(busy_r) && $past(state_r == dac_pkg::DAC_ST_FAIL)) |-> cmderr_r != 3'h0)
        else $error("busy cleared before error recorded");
endmodule

// ===== hdl/dac_cfg.svh
// Purpose: constants for the abstract command control block
// Assumes: debug module interface word addresses of 7 bits
// Notes: definitions only
`ifndef DAC_CFG_SVH
`define DAC_CFG_SVH
`define DAC_ADDR_W 7
`define DAC_OFS_CTRL_STATUS 7'h16
`define DAC_OFS_CMD_LAUNCH 7'h17
`define DAC_OFS_ARG_ZERO 7'h04
`define DAC_OFS_ARG_ONE 7'h05
`define DAC_CS_BUSY_BIT 12
`define DAC_CS_ERR_HI 10
`define DAC_CS_ERR_LO 8
`define DAC_CS_PBUF_HI 28
`define DAC_CS_PBUF_LO 24
`define DAC_CS_DCNT_HI 3
`define DAC_CS_DCNT_LO 0
`define DAC_DATA_COUNT 4'h2
`define DAC_PBUF_SIZE 5'h00
`define DAC_ERR_CLEAR_ALL 3'h7
`define DAC_CMD_TYPE_HI 31
`define DAC_CMD_TYPE_LO 24
`define DAC_CMD_SIZE_HI 22
`define DAC_CMD_SIZE_LO 20
`define DAC_CMD_REGNO_HI 15
`define DAC_CMD_REGNO_LO 0
`define DAC_SIZE_WORD 3'h2
`define DAC_REGNO_LAST 16'h101F
`define DAC_ALIGN_MASK 32'h0000_0003
`endif

// ===== hdl/dac_pkg.sv
// Purpose: types for the abstract command control block
// Assumes: shared by the control module and the command checker
// Notes: error codes follow the status field encoding
package dac_pkg;
    typedef enum logic [2:0] {
        DAC_ERR_NONE = 3'h0,
        DAC_ERR_BUSY = 3'h1,
        DAC_ERR_UNSUPPORTED = 3'h2,
        DAC_ERR_EXCEPTION = 3'h3,
        DAC_ERR_HART_STATE = 3'h4,
        DAC_ERR_OTHER = 3'h7
    } dac_err_type;
    typedef enum logic [7:0] {
        DAC_CMD_REG_ACCESS = 8'h00,
        DAC_CMD_MEM_ACCESS = 8'h02
    } dac_cmd_kind_type;
    typedef enum {
        DAC_ST_IDLE,
        DAC_ST_EXEC,
        DAC_ST_FAIL
    } dac_state_type;
endpackage

// ===== hdl/dac_cmd_check.sv
// Purpose: combinational legality check of one abstract command
// Assumes: hart flags and address come from logic on core_clk
// Notes: yields zero when the command may run
`include "dac_cfg.svh"
module dac_cmd_check #(
    parameter logic [31:0] IMEM_BASE = 32'h1000_0000,
    parameter logic [31:0] IMEM_SIZE = 32'h0001_0000,
    parameter logic [31:0] DMEM_BASE = 32'h2000_0000,
    parameter logic [31:0] DMEM_SIZE = 32'h0001_0000,
    parameter logic [31:0] INTR_BASE = 32'h3000_0000,
    parameter logic [31:0] INTR_SIZE = 32'h0001_0000
) (
    // command
    input wire logic [31:0] cmd_word,
    input wire logic [31:0] mem_addr,
    // hart state
    input wire logic hart_halted,
    input wire logic hart_unavail,
    // result
    output logic [2:0] err_code
);
    function automatic logic in_range(input logic [31:0] a, input logic [31:0] base,
                                      input logic [31:0] size);
        in_range = (a >= base) && ((a - base) < size);
    endfunction

    wire logic [7:0] cmd_type = cmd_word[`DAC_CMD_TYPE_HI:`DAC_CMD_TYPE_LO];
    wire logic [2:0] cmd_size = cmd_word[`DAC_CMD_SIZE_HI:`DAC_CMD_SIZE_LO];
    wire logic [15:0] regno = cmd_word[`DAC_CMD_REGNO_HI:`DAC_CMD_REGNO_LO];
    wire logic is_reg = cmd_type == dac_pkg::DAC_CMD_REG_ACCESS; // [R17]
    wire logic is_mem = cmd_type == dac_pkg::DAC_CMD_MEM_ACCESS; // [R17]
    wire logic addr_ok = in_range(mem_addr, IMEM_BASE, IMEM_SIZE)
                       || in_range(mem_addr, DMEM_BASE, DMEM_SIZE)
                       || in_range(mem_addr, INTR_BASE, INTR_SIZE); // [R16]
    wire logic unaligned = (mem_addr & `DAC_ALIGN_MASK) != 32'h0;

    always_comb begin
        err_code = dac_pkg::DAC_ERR_NONE;
        if (!is_reg && !is_mem) begin
            err_code = dac_pkg::DAC_ERR_UNSUPPORTED; // [R6]
        end else if (cmd_size != `DAC_SIZE_WORD) begin
            err_code = dac_pkg::DAC_ERR_OTHER; // [R9] [R18]
        end else if (is_reg) begin
            if (hart_unavail || !hart_halted) begin
                err_code = dac_pkg::DAC_ERR_HART_STATE; // [R8]
            end else if (regno > `DAC_REGNO_LAST) begin
                err_code = dac_pkg::DAC_ERR_UNSUPPORTED; // [R6]
            end
        end else if (hart_unavail) begin
            err_code = dac_pkg::DAC_ERR_HART_STATE; // [R8]
        end else if (unaligned) begin
            err_code = dac_pkg::DAC_ERR_OTHER; // [R9]
        end else if (!addr_ok) begin
            err_code = dac_pkg::DAC_ERR_EXCEPTION; // [R7] [R16]
        end
    end
endmodule

// ===== bench/dac_core_model.sv
// Purpose: core side of the execution port, answers each started command
// Assumes: one command at a time, done_delay of at least 1
// Notes: exec_err is scrambled outside the done pulse
module dac_core_model (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // command from the control block
    input wire logic exec_start_r,
    // behaviour chosen by the bench
    input wire logic [7:0] done_delay,
    input wire logic [2:0] done_err,
    // answer
    output logic exec_done,
    output logic [2:0] exec_err
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt_r;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cnt_r <= 8'h00;
            exec_done <= 1'h0;
        end else begin
            exec_done <= (cnt_r == 8'h01);
            if (exec_start_r)
                cnt_r <= done_delay;
            else if (cnt_r != 8'h00)
                cnt_r <= cnt_r - 8'h01;
        end
    end
    // code only valid with done
    assign exec_err = exec_done ? done_err : ~done_err;
endmodule

// ===== bench/dac_ctrl_bench.sv
// Purpose: self-checking bench for the abstract command control block
// Assumes: default memory ranges of the design
// Notes: inputs change at the falling edge
`include "dac_cfg.svh"
module dac_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk, rst, dm_active, valid, write, halted, unavail;
    logic [6:0] addr;
    logic [31:0] wdata, arg1, q, rdata, cmd;
    logic rsp_valid, start, done, busy;
    logic [2:0] eerr, merr, err;
    logic [7:0] dly;
    int miscompares = 0;
    int n_compared = 0;
    int starts = 0;
    int s0;
    dac_ctrl dut_u (.core_clk(core_clk), .rst(rst), .dm_active(dm_active),
        .dmi_req_valid(valid), .dmi_req_write(write), .dmi_req_addr(addr),
        .dmi_req_wdata(wdata), .dmi_rsp_valid_r(rsp_valid), .dmi_rsp_rdata_r(rdata),
        .hart_halted(halted), .hart_unavail(unavail), .argument_word_one(arg1),
        .exec_start_r(start), .exec_cmd_r(cmd), .exec_done(done), .exec_err(eerr),
        .busy_r(busy), .cmderr_r(err));
    dac_core_model core_u (.core_clk(core_clk), .rst(rst), .exec_start_r(start),
        .done_delay(dly), .done_err(merr), .exec_done(done), .exec_err(eerr));
    always #2.5 core_clk = ~core_clk;
    always @(posedge core_clk) if (start === 1'h1) starts++;
    function automatic logic [31:0] mk(logic [7:0] t, logic [2:0] s, logic [15:0] r);
        return {t, 1'h0, s, 4'h0, r};
    endfunction
    function automatic logic [31:0] st(logic b, logic [2:0] e);
        return {19'h0, b, 1'h0, e, 4'h0, 4'h2};
    endfunction
    task automatic complete_run;
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic dmi(input logic w, input logic [6:0] a, input logic [31:0] d);
        @(negedge core_clk);
        valid = 1'h1; write = w; addr = a; wdata = d;
        @(negedge core_clk);
        valid = 1'h0;
        q = rdata;
        check("rsp_valid", {31'h0, rsp_valid}, 32'h1);
    endtask
    task automatic wait_idle;
        for (int i = 0; i < 200 && busy !== 1'h0; i++) @(negedge core_clk);
        if (busy !== 1'h0) begin
            check("busy_wait", {31'h0, busy}, 32'h0);
            complete_run;
        end
    endtask
    task automatic clear_err;
        dmi(1'h1, `DAC_OFS_CTRL_STATUS, 32'h0000_0700);
        check("cmderr_clear", {29'h0, err}, 32'h0);
    endtask
    task automatic busy_case(input logic w, input logic [6:0] a, input logic [31:0] d);
        dly = 8'h1E; halted = 1'h1; unavail = 1'h0; s0 = starts;
        dmi(1'h1, `DAC_OFS_CMD_LAUNCH, mk(8'h00, 3'h2, 16'h1000));
        dmi(w, a, d);
        check("cmderr_busy", {29'h0, err}, 32'h1);
        wait_idle;
        check("one_start", starts - s0, 32'h1);
        clear_err;
    endtask
    task automatic run_case(input logic [31:0] c, input logic [31:0] a, input logic h,
        input logic u, input logic [2:0] me, input logic [2:0] exp, input int ns);
        dly = 8'h03; halted = h; unavail = u; arg1 = a; merr = me; s0 = starts;
        dmi(1'h1, `DAC_OFS_CMD_LAUNCH, c);
        check("busy_on_cmd", {31'h0, busy}, 32'h1);
        wait_idle;
        check("cmderr_code", {29'h0, err}, {29'h0, exp});
        check("start_count", starts - s0, ns);
        if (ns == 1) check("exec_cmd", cmd, c);
        if (exp != 3'h0) begin
            s0 = starts; halted = 1'h1; unavail = 1'h0;
            dmi(1'h1, `DAC_OFS_CMD_LAUNCH, mk(8'h00, 3'h2, 16'h1000));
            check("blocked_busy", {31'h0, busy}, 32'h0);
            dmi(1'h1, `DAC_OFS_CTRL_STATUS, 32'h0000_0600);
            check("blocked_start", starts - s0, 32'h0);
            check("cmderr_hold", {29'h0, err}, {29'h0, exp});
            clear_err;
        end
    endtask
    initial begin
        core_clk = 1'h0; rst = 1'h1; dm_active = 1'h1; valid = 1'h0; write = 1'h0;
        addr = 7'h00; wdata = 32'h0; halted = 1'h1; unavail = 1'h0; arg1 = 32'h0;
        dly = 8'h03; merr = 3'h0;
        repeat (6) @(posedge core_clk);
        @(negedge core_clk);
        rst = 1'h0;
        dmi(1'h0, `DAC_OFS_CTRL_STATUS, 32'h0);
        check("status_reset", q, st(1'h0, 3'h0));
        dly = 8'h0A;
        dmi(1'h1, `DAC_OFS_CMD_LAUNCH, mk(8'h00, 3'h2, 16'h101F));
        dmi(1'h0, `DAC_OFS_CTRL_STATUS, 32'h0);
        check("status_busy", q, st(1'h1, 3'h0));
        wait_idle;
        dmi(1'h0, `DAC_OFS_CTRL_STATUS, 32'h0);
        check("status_idle", q, st(1'h0, 3'h0));
        busy_case(1'h1, `DAC_OFS_CMD_LAUNCH, mk(8'h00, 3'h2, 16'h1000));
        busy_case(1'h1, `DAC_OFS_CTRL_STATUS, 32'h0);
        busy_case(1'h1, `DAC_OFS_CTRL_STATUS, 32'h0000_0700);
        busy_case(1'h0, `DAC_OFS_ARG_ZERO, 32'h0);
        busy_case(1'h1, `DAC_OFS_ARG_ONE, 32'h0);
        run_case(mk(8'h01, 3'h2, 16'h1000), 32'h0, 1'h1, 1'h0, 3'h0, 3'h2, 0);
        run_case(mk(8'h00, 3'h3, 16'h1000), 32'h0, 1'h1, 1'h0, 3'h0, 3'h7, 0);
        run_case(mk(8'h00, 3'h2, 16'h1000), 32'h0, 1'h0, 1'h0, 3'h0, 3'h4, 0);
        run_case(mk(8'h00, 3'h2, 16'h1020), 32'h0, 1'h1, 1'h0, 3'h0, 3'h2, 0);
        run_case(mk(8'h02, 3'h2, 16'h0), 32'h2000_0000, 1'h0, 1'h1, 3'h0, 3'h4, 0);
        run_case(mk(8'h02, 3'h2, 16'h0), 32'h1000_0001, 1'h0, 1'h0, 3'h0, 3'h7, 0);
        run_case(mk(8'h02, 3'h1, 16'h0), 32'h1000_0000, 1'h0, 1'h0, 3'h0, 3'h7, 0);
        run_case(mk(8'h02, 3'h2, 16'h0), 32'h0000_1000, 1'h0, 1'h0, 3'h0, 3'h3, 0);
        run_case(mk(8'h02, 3'h2, 16'h0), 32'h3000_0010, 1'h0, 1'h0, 3'h0, 3'h0, 1);
        run_case(mk(8'h02, 3'h2, 16'h0), 32'h2000_0000, 1'h0, 1'h0, 3'h3, 3'h3, 1);
        run_case(mk(8'h02, 3'h3, 16'h0), 32'h2000_0000, 1'h0, 1'h0, 3'h0, 3'h7, 0);
        run_case(mk(8'h01, 3'h2, 16'h0), 32'h0, 1'h1, 1'h0, 3'h0, 3'h2, 0);
        dmi(1'h1, `DAC_OFS_CMD_LAUNCH, mk(8'h05, 3'h2, 16'h0));
        wait_idle;
        @(negedge core_clk);
        dm_active = 1'h0;
        repeat (2) @(negedge core_clk);
        dm_active = 1'h1;
        dmi(1'h0, `DAC_OFS_CTRL_STATUS, 32'h0);
        check("status_after_inactive", q, st(1'h0, 3'h0));
        complete_run;
    end
endmodule
